// [src/herd_defines.vh]
// register offsets, field positions and timing counts for the register decoder
`ifndef HERD_DEFINES_VH
`define HERD_DEFINES_VH
`define HERD_ADDR_DLO 3'h0
`define HERD_ADDR_DMID 3'h1
`define HERD_ADDR_DHI 3'h2
`define HERD_ADDR_SLEEP 3'h3
`define HERD_ADDR_PSYNC 3'h4
`define HERD_ADDR_SSYNC 3'h5
`define HERD_ADDR_CAP 3'h6
`define HERD_ADDR_ACW 3'h7
`define HERD_ACW_AUTOINC 7
`define HERD_ACW_BCAST 6
`define HERD_SLEEP_IOSEL 5
`define HERD_SS_START 4
`define HERD_SS_HOP 5
`define HERD_SS_TEST 6
`define HERD_SS_PN 7
`define HERD_RST_BYTE 8'h00
`define HERD_NEG_FULL 14'h2000
`define HERD_HOLDOFF_RST 16'h0000
`define HERD_PN_SEED 15'h7fff
`endif

// [src/herd_group.v]
// one copy of the eight external registers and its access decoder
`timescale 1ns/10ps
`include "herd_defines.vh"
module herd_group #(
   parameter SAMPLE_W = 14
) (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // register access, one cycle strobes
   input wire sel,
   input wire wr_stb,
   input wire rd_stb,
   input wire [2:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata,
   // identity straps of this group
   input wire [2:0] chip_identity_pins,
   // internal access toward channel memory
   output reg int_wr,
   output reg int_rd,
   output reg [3:0] int_chan_grant,
   output reg int_io_space,
   output reg [7:0] int_addr,
   output reg [19:0] int_wdata,
   input wire [19:0] int_rdata,
   // sync and test source controls
   output reg [3:0] sync_pulse,
   output reg start_pulse,
   output reg hop_req,
   input wire [15:0] holdoff_count,
   output reg hop_update,
   output reg [3:0] sleep_chan,
   output reg [7:0] pin_sync_ctrl,
   output reg test_source_enable,
   output reg pseudorandom_source_select,
   output reg [SAMPLE_W-1:0] test_sample
);
   reg [7:0] access_control_word_q;
   reg [7:0] channel_address_pointer_q;
   reg [7:0] data_low_byte_q;
   reg [7:0] data_middle_byte_q;
   reg [3:0] data_high_nibble_q;
   reg [14:0] pn_q;
   reg hop_pend_q;
   reg [3:0] grant_d;
   reg [3:0] one_chan;
   reg sleep_chan_io_q;
   wire int_io_space_w = sleep_chan_io_q;
   wire bcast = access_control_word_q[`HERD_ACW_BCAST];
   wire [3:0] instr = access_control_word_q[5:2];
   wire [1:0] chsel = access_control_word_q[1:0];
   wire dlo_acc = sel & (wr_stb | rd_stb) & (addr == `HERD_ADDR_DLO);

   // channel grant from the instruction; undecodable codes grant nothing
   always @* begin
      one_chan = 4'h1 << chsel;
      if (int_io_space_w)
         one_chan = 4'hf;
      if (!bcast) begin
         grant_d = (instr[2:0] == chip_identity_pins) ? one_chan : 4'h0;
      end else begin
         case (instr)
            4'h0: grant_d = 4'hf;
            4'h1: grant_d = 4'h7;
            4'h2: grant_d = 4'he;
            4'h4, 4'h8: grant_d = one_chan;
            4'hc: grant_d = chip_identity_pins[0] ? 4'h0 : one_chan;
            4'he: grant_d = chip_identity_pins[0] ? one_chan : 4'h0;
            default: grant_d = 4'h0;
         endcase
      end
   end

   // register writes, internal access launch and pointer increment
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         access_control_word_q <= `HERD_RST_BYTE;
         channel_address_pointer_q <= `HERD_RST_BYTE;
         data_low_byte_q <= `HERD_RST_BYTE;
         data_middle_byte_q <= `HERD_RST_BYTE;
         data_high_nibble_q <= 4'h0;
         sleep_chan <= 4'h0;
         sleep_chan_io_q <= 1'b0;
         pin_sync_ctrl <= `HERD_RST_BYTE;
         test_source_enable <= 1'b0;
         pseudorandom_source_select <= 1'b0;
         sync_pulse <= 4'h0;
         start_pulse <= 1'b0;
         hop_req <= 1'b0;
         int_wr <= 1'b0;
         int_rd <= 1'b0;
         int_chan_grant <= 4'h0;
         int_io_space <= 1'b0;
         int_addr <= `HERD_RST_BYTE;
         int_wdata <= 20'h00000;
      end else begin
         sync_pulse <= 4'h0;
         start_pulse <= 1'b0;
         hop_req <= 1'b0;
         int_wr <= 1'b0;
         int_rd <= 1'b0;
         if (sel && wr_stb) begin
            case (addr)
               `HERD_ADDR_ACW: access_control_word_q <= wdata;
               `HERD_ADDR_CAP: channel_address_pointer_q <= wdata;
               `HERD_ADDR_SSYNC: begin
                  sync_pulse <= wdata[3:0];
                  start_pulse <= wdata[`HERD_SS_START] & |wdata[3:0];
                  hop_req <= wdata[`HERD_SS_HOP] & |wdata[3:0];
                  test_source_enable <= wdata[`HERD_SS_TEST];
                  pseudorandom_source_select <= wdata[`HERD_SS_PN];
               end
               `HERD_ADDR_PSYNC: pin_sync_ctrl <= wdata;
               `HERD_ADDR_SLEEP: begin
                  sleep_chan <= wdata[3:0];
                  sleep_chan_io_q <= wdata[`HERD_SLEEP_IOSEL];
               end
               `HERD_ADDR_DHI: data_high_nibble_q <= wdata[3:0];
               `HERD_ADDR_DMID: data_middle_byte_q <= wdata;
               default: data_low_byte_q <= wdata;
            endcase
         end
         if (dlo_acc) begin
            int_wr <= wr_stb;
            int_rd <= rd_stb;
            int_chan_grant <= grant_d;
            int_io_space <= sleep_chan_io_q;
            int_addr <= channel_address_pointer_q;
            int_wdata <= {data_high_nibble_q, data_middle_byte_q, wdata};
            if (access_control_word_q[`HERD_ACW_AUTOINC])
               channel_address_pointer_q <= channel_address_pointer_q
                  + 8'h01;
         end
         // read data of the launched access lands in the data registers
         if (int_rd) begin
            data_low_byte_q <= int_rdata[7:0];
            data_middle_byte_q <= int_rdata[15:8];
            data_high_nibble_q <= int_rdata[19:16];
         end
      end
   end

   // hop waits for the holdoff counter to reach zero
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hop_pend_q <= 1'b0;
         hop_update <= 1'b0;
      end else begin
         hop_update <= 1'b0;
         if (hop_req)
            hop_pend_q <= 1'b1;
         else if (hop_pend_q && holdoff_count == `HERD_HOLDOFF_RST) begin
            hop_pend_q <= 1'b0;
            hop_update <= 1'b1;
         end
      end
   end

   // test source: constant negative full scale or pseudorandom stream
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pn_q <= `HERD_PN_SEED;
         test_sample <= {SAMPLE_W{1'b0}};
      end else begin
         if (test_source_enable && pseudorandom_source_select)
            pn_q <= {pn_q[13:0], pn_q[14] ^ pn_q[13]};
         if (!test_source_enable)
            test_sample <= {SAMPLE_W{1'b0}};
         else if (pseudorandom_source_select)
            test_sample <= pn_q[SAMPLE_W-1:0];
         else
            test_sample <= `HERD_NEG_FULL;
      end
   end

   // readback; pointer hidden under broadcast, write-only registers read zero
   always @* begin
      case (addr)
         `HERD_ADDR_ACW: rdata = access_control_word_q;
         `HERD_ADDR_CAP: rdata = bcast ? 8'h00 :
            channel_address_pointer_q;
         `HERD_ADDR_DHI: rdata = {4'h0, data_high_nibble_q};
         `HERD_ADDR_DMID: rdata = data_middle_byte_q;
         `HERD_ADDR_DLO: rdata = data_low_byte_q;
         default: rdata = 8'h00;
      endcase
   end
endmodule // herd_group

// [src/herd_top.v]
// two select-gated copies of the external register space, parallel or serial
// Summary of operation
// - two copies, each opened by own select
// - three-bit address picks one of eight registers
// - serial port reaches identical register map
// - auto-increment bumps pointer after low-byte access
// - non-broadcast accesses need identity pin match
// - broadcast codes 0,1,2 grant channel sets
// - broadcast 4,8,c,e grant chips, one channel
// - control bits 1:0 pick single channel
// - io space disables channel bit decode
// - pointer holds address, hidden under broadcast
// - soft-sync bits 0-3 sync four channels
// - soft-sync bit 4 adds a start
// - soft-sync bit 5 hops after holdoff
// - soft-sync bit 6 selects test source
// - bit 7 picks negative full-scale or pseudorandom
// - low data register access launches transfer
// - sleep bit 5 points into io space
`timescale 1ns/10ps
`include "herd_defines.vh"
module herd_top #(
   parameter SAMPLE_W = 14
) (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // parallel host port, one-cycle strobes
   input wire group_a_select_n,
   input wire group_b_select_n,
   input wire host_wr,
   input wire host_rd,
   input wire [2:0] host_addr,
   input wire [7:0] host_wdata,
   output wire [7:0] host_rdata,
   // serial port after deframing; same map, takes priority
   input wire ser_sel_b,
   input wire ser_wr,
   input wire ser_rd,
   input wire [2:0] ser_addr,
   input wire [7:0] ser_wdata,
   output wire [7:0] ser_rdata,
   // identity straps
   input wire [2:0] chip_identity_pins_a,
   input wire [2:0] chip_identity_pins_b,
   // internal access, group a then group b
   output wire [1:0] int_wr,
   output wire [1:0] int_rd,
   output wire [7:0] int_chan_grant,
   output wire [1:0] int_io_space,
   output wire [15:0] int_addr,
   output wire [39:0] int_wdata,
   input wire [39:0] int_rdata,
   // sync and test outputs
   output wire [7:0] sync_pulse,
   output wire [1:0] start_pulse,
   input wire [31:0] holdoff_count,
   output wire [1:0] hop_update,
   output wire [7:0] sleep_chan,
   output wire [15:0] pin_sync_ctrl,
   output wire [1:0] test_source_enable,
   output wire [1:0] pseudorandom_source_select,
   output wire [2*SAMPLE_W-1:0] test_sample
);
   wire ser_act = ser_wr | ser_rd;
   wire [1:0] sel;
   wire wr = ser_act ? ser_wr : host_wr;
   wire rd = ser_act ? ser_rd : host_rd;
   wire [2:0] addr = ser_act ? ser_addr : host_addr;
   wire [7:0] wdata = ser_act ? ser_wdata : host_wdata;
   wire [7:0] rd_a;
   wire [7:0] rd_b;
   // serial preempts the microport in the cycle both strobe
   assign sel[0] = ser_act ? ~ser_sel_b : ~group_a_select_n;
   assign sel[1] = ser_act ? ser_sel_b : ~group_b_select_n;
   assign host_rdata = !group_a_select_n ? rd_a :
      (!group_b_select_n ? rd_b : 8'h00);
   assign ser_rdata = ser_sel_b ? rd_b : rd_a;

   wire [2:0] ids [0:1];
   assign ids[0] = chip_identity_pins_a;
   assign ids[1] = chip_identity_pins_b;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : grp
         wire [7:0] rd_g;
         herd_group #(.SAMPLE_W(SAMPLE_W)) u_grp (
            .clk(clk),
            .arst_n(arst_n),
            .sel(sel[g]),
            .wr_stb(wr),
            .rd_stb(rd),
            .addr(addr),
            .wdata(wdata),
            .rdata(rd_g),
            .chip_identity_pins(ids[g]),
            .int_wr(int_wr[g]),
            .int_rd(int_rd[g]),
            .int_chan_grant(int_chan_grant[4*g+3:4*g]),
            .int_io_space(int_io_space[g]),
            .int_addr(int_addr[8*g+7:8*g]),
            .int_wdata(int_wdata[20*g+19:20*g]),
            .int_rdata(int_rdata[20*g+19:20*g]),
            .sync_pulse(sync_pulse[4*g+3:4*g]),
            .start_pulse(start_pulse[g]),
            .hop_req(),
            .holdoff_count(holdoff_count[16*g+15:16*g]),
            .hop_update(hop_update[g]),
            .sleep_chan(sleep_chan[4*g+3:4*g]),
            .pin_sync_ctrl(pin_sync_ctrl[8*g+7:8*g]),
            .test_source_enable(test_source_enable[g]),
            .pseudorandom_source_select(pseudorandom_source_select[g]),
            .test_sample(test_sample[SAMPLE_W*g+SAMPLE_W-1:SAMPLE_W*g])
         );
      end
   endgenerate
   assign rd_a = grp[0].rd_g;
   assign rd_b = grp[1].rd_g;
endmodule // herd_top

// [dv/herd_chan_mem.sv]
// channel memory model standing behind both register groups
`timescale 1ns/10ps
module herd_chan_mem (
   // clock
   input wire clk,
   // internal access from the decoder
   input wire [1:0] int_wr,
   input wire [15:0] int_addr,
   input wire [39:0] int_wdata,
   output wire [39:0] int_rdata
);
   reg [19:0] mem_a [0:255];
   reg [19:0] mem_b [0:255];
   // a write lands whatever the grant, so reads must target written cells
   always @(posedge clk) begin
      if (int_wr[0])
         mem_a[int_addr[7:0]] <= int_wdata[19:0];
      if (int_wr[1])
         mem_b[int_addr[15:8]] <= int_wdata[39:20];
   end
   // no handshake on this side: data must be there in the strobe cycle
   assign int_rdata = {mem_b[int_addr[15:8]], mem_a[int_addr[7:0]]};
endmodule // herd_chan_mem

// [dv/herd_checker.sv]
// concurrent checks on the group a host and serial sides of the decoder
`timescale 1ns/10ps
module herd_checker (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // host and serial access
   input wire group_a_select_n,
   input wire group_b_select_n,
   input wire host_wr,
   input wire host_rd,
   input wire [2:0] host_addr,
   input wire [7:0] host_rdata,
   input wire ser_sel_b,
   input wire ser_wr,
   input wire ser_rd,
   input wire [2:0] ser_addr,
   // decoder outputs
   input wire [1:0] int_wr,
   input wire [1:0] int_rd,
   input wire [7:0] sync_pulse,
   input wire [1:0] hop_update,
   input wire [31:0] holdoff_count
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire host_a = !group_a_select_n && !ser_wr && !ser_rd;
   wire ser_a = ser_wr && !ser_sel_b;
   wire wr_lo = host_a && host_wr && host_addr == 3'h0
      || ser_a && ser_addr == 3'h0;
   wire rd_lo = host_a && host_rd && host_addr == 3'h0
      || ser_rd && !ser_sel_b && ser_addr == 3'h0;
   wire wr_ss = host_a && host_wr && host_addr == 3'h5
      || ser_a && ser_addr == 3'h5;
   wire hold_zero = holdoff_count[15:0] == 16'h0000;
   wire only_a = host_a && group_b_select_n;
   sequence s_lowrd_a;
      host_a && host_rd && host_addr == 3'h0;
   endsequence
   sequence s_rd_out;
      ##1 int_rd[0];
   endsequence
   a_rd_launch: assert property (s_lowrd_a |-> s_rd_out)
      else $error("low byte read did not launch");
   a_wr_cause: assert property (int_wr[0] |-> $past(wr_lo))
      else $error("internal write without low byte write");
   a_rd_cause: assert property (int_rd[0] |-> $past(rd_lo))
      else $error("internal read without low byte read");
   a_wo_zero: assert property (only_a && host_addr inside {3'h3, 3'h4,
      3'h5} |-> host_rdata == 8'h00)
      else $error("write-only register read nonzero");
   a_none_sel: assert property (group_a_select_n &&
      group_b_select_n |-> host_rdata == 8'h00)
      else $error("readback with no group selected");
   a_dhi_nibble: assert property (only_a && host_addr == 3'h2
      |-> host_rdata[7:4] == 4'h0)
      else $error("high data register upper bits nonzero");
   a_hop_wait: assert property (hop_update[0] |-> $past(hold_zero))
      else $error("hop update before holdoff reached zero");
   a_sync_cause: assert property (sync_pulse[3:0] != 4'h0
      |-> $past(wr_ss))
      else $error("sync pulse without soft sync write");
endmodule // herd_checker
bind herd_top herd_checker u_chk (.*);

// [dv/host_external_register_decoder_tb_top.sv]
// directed bench for the two-group register decoder
`timescale 1ns/10ps
module host_external_register_decoder_tb_top;
   logic clk = 1'b0, arst_n = 1'b0, use_ser = 1'b0;
   logic group_a_select_n = 1'b1, group_b_select_n = 1'b1, ser_sel_b = 1'b0;
   logic host_wr = 1'b0, host_rd = 1'b0, ser_wr = 1'b0, ser_rd = 1'b0;
   logic [2:0] host_addr = 3'h0, ser_addr = 3'h0;
   logic [2:0] chip_identity_pins_a = 3'h5, chip_identity_pins_b = 3'h2;
   logic [7:0] host_wdata = 8'h00, ser_wdata = 8'h00;
   logic [31:0] holdoff_count = 32'h0;
   wire [7:0] host_rdata, ser_rdata, int_chan_grant, sync_pulse, sleep_chan;
   wire [1:0] int_wr, int_rd, int_io_space, start_pulse, hop_update;
   wire [1:0] test_source_enable, pseudorandom_source_select;
   wire [15:0] int_addr, pin_sync_ctrl;
   wire [39:0] int_wdata, int_rdata;
   wire [27:0] test_sample;
   int mismatches = 0, checked = 0;
   herd_top u_dut (.*);
   herd_chan_mem u_mem (.*);
   always #4 clk = ~clk;
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sel(input logic g);
      group_a_select_n = g;
      group_b_select_n = !g;
      ser_sel_b = g;
   endtask
   // strobes last one cycle; a spare falling edge keeps calls apart
   task automatic acc(input logic w, input logic [2:0] a,
         input logic [7:0] d, input logic [7:0] e);
      @(negedge clk);
      {ser_addr, ser_wdata, host_addr, host_wdata} = {a, d, a, d};
      {ser_wr, ser_rd} = {2{use_ser}} & {w, !w};
      {host_wr, host_rd} = {2{!use_ser}} & {w, !w};
      #1 if (!w) chk(use_ser ? ser_rdata : host_rdata, e);
      @(negedge clk);
      {ser_wr, ser_rd, host_wr, host_rd} = 4'h0;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, a, d, 8'h00);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00, e);
   endtask
   task automatic t_regs;
      sel(1'b0);
      rd(3'h7, 8'h00);
      wr(3'h7, 8'h96);
      wr(3'h6, 8'h10);
      wr(3'h2, 8'hf4);
      wr(3'h1, 8'h23);
      rd(3'h7, 8'h96);
      rd(3'h6, 8'h10);
      rd(3'h2, 8'h04);
      for (int i = 3; i < 6; i++)
         rd(i[2:0], 8'h00);
      $display("test regs done");
   endtask
   task automatic t_wr;
      wr(3'h0, 8'h45);
      chk(int_wr[0], 1'b1);
      chk(int_addr[7:0], 8'h10);
      chk(int_chan_grant[3:0], 4'h4);
      chk(int_wdata[19:0], 20'h42345);
      rd(3'h6, 8'h11);
      chip_identity_pins_a = 3'h3;
      wr(3'h0, 8'h45);
      chk(int_chan_grant[3:0], 4'h0);
      chip_identity_pins_a = 3'h5;
      $display("test write done");
   endtask
   task automatic t_rd;
      wr(3'h7, 8'h16);
      wr(3'h6, 8'h10);
      wr(3'h1, 8'h99);
      wr(3'h2, 8'h0b);
      rd(3'h0, 8'h45);
      chk(int_rd[0], 1'b1);
      rd(3'h1, 8'h23);
      rd(3'h2, 8'h04);
      $display("test read done");
   endtask
   task automatic t_bc;
      logic [3:0] code [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'he, 4'h3};
      logic [3:0] gnt [8] = '{4'hf, 4'h7, 4'he, 4'h8, 4'h8, 4'h0, 4'h8, 4'h0};
      for (int i = 0; i < 8; i++) begin
         wr(3'h7, {2'b01, code[i], 2'b11});
         wr(3'h0, 8'h00);
         chk(int_chan_grant[3:0], gnt[i]);
      end
      rd(3'h6, 8'h00);
      wr(3'h7, 8'h16);
      $display("test broadcast done");
   endtask
   task automatic t_sync;
      int n;
      holdoff_count = 32'h5;
      wr(3'h5, 8'h33);
      chk(sync_pulse[3:0], 4'h3);
      chk(start_pulse[0], 1'b1);
      // give the pending hop time to misfire while holdoff is nonzero
      repeat (2) @(negedge clk);
      chk(hop_update[0], 1'b0);
      holdoff_count = 32'h0;
      for (n = 0; n < 20 && hop_update[0] !== 1'b1; n++)
         @(negedge clk);
      chk(hop_update[0], 1'b1);
      wr(3'h5, 8'h40);
      @(negedge clk);
      chk(test_source_enable[0], 1'b1);
      chk(test_sample[13:0], 14'h2000);
      wr(3'h5, 8'hc0);
      @(negedge clk);
      chk(pseudorandom_source_select[0], 1'b1);
      chk(test_sample[13:0] == 14'h2000, 1'b0);
      wr(3'h5, 8'h00);
      @(negedge clk);
      chk(test_source_enable[0], 1'b0);
      $display("test sync done");
   endtask
   task automatic t_io;
      wr(3'h3, 8'h25);
      wr(3'h4, 8'h3c);
      chk(pin_sync_ctrl[7:0], 8'h3c);
      wr(3'h0, 8'h00);
      chk(int_io_space[0], 1'b1);
      chk(sleep_chan[3:0], 4'h5);
      chk(int_chan_grant[3:0] == 4'h4, 1'b0);
      wr(3'h3, 8'h00);
      wr(3'h0, 8'h00);
      chk(int_io_space[0], 1'b0);
      chk(int_chan_grant[3:0], 4'h4);
      $display("test io space done");
   endtask
   task automatic t_grp_b;
      sel(1'b1);
      wr(3'h7, 8'h0a);
      wr(3'h6, 8'h33);
      wr(3'h0, 8'h77);
      chk(int_wr, 2'b10);
      chk(int_addr[15:8], 8'h33);
      chk(int_chan_grant, 8'h44);
      wr(3'h5, 8'h08);
      chk(sync_pulse, 8'h80);
      sel(1'b0);
      rd(3'h6, 8'h10);
      $display("test group b done");
   endtask
   task automatic t_ser;
      use_ser = 1'b1;
      wr(3'h6, 8'h5a);
      rd(3'h6, 8'h5a);
      use_ser = 1'b0;
      rd(3'h6, 8'h5a);
      group_a_select_n = 1'b1;
      @(negedge clk);
      chk(host_rdata, 8'h00);
      $display("test serial done");
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      t_regs;
      t_wr;
      t_rd;
      t_bc;
      t_sync;
      t_io;
      t_grp_b;
      t_ser;
      report_and_stop;
   end
   initial begin
      #100000;
      mismatches++;
      report_and_stop;
   end
endmodule // host_external_register_decoder_tb_top
